// ### verilog/lpc_pkg.sv
// Behaviour
// - undervoltage lockout forces every LED channel off whatever the registers hold.
// - on enable rising the device wakes with all channel currents at zero.
// - enable held low keeps the device in zero-current shutdown.
// - in shutdown every channel output is high impedance and sinks nothing.
// - configuration lives in four 6-bit registers, three pair codes and one mask.
// - pair code registers zero, one and two drive pairs A, B and C.
// - mask bits 0..5 switch channels A1, A2, B1, B2, C1, C2; one means on.
// - all four registers can be written and read over the serial data line.
// - mode sequencer starts in 1x and stays while regulation holds.
// - lost regulation moves the sequencer to 1.5x after 400 microseconds.
// - power-up and every shutdown exit restart mode evaluation in 1x.
// - each write to the on/off mask restarts mode evaluation.
// - only slave address 1100110 is answered; the testbench also sends one write to 1100111.
// - read is index write, repeated start, one read byte, then NACK and stop.
// - code low six bits give (code+1) x 0.5 mA; top two bits ignored.
package lpc_pkg;
    // serial slave address
    localparam logic [6:0] SLAVE_ADDR      = 7'h66;
    // register indices
    localparam logic [7:0] IDX_PAIR_A      = 8'h00;
    localparam logic [7:0] IDX_PAIR_B      = 8'h01;
    localparam logic [7:0] IDX_PAIR_C      = 8'h02;
    localparam logic [7:0] IDX_ON_OFF      = 8'h03;
    localparam logic [7:0] NUM_REGS        = 8'h04;
    localparam int         CODE_W          = 6;
    localparam logic [5:0] CODE_RESET      = 6'h00;
    localparam logic [3:0] BYTE_BITS       = 4'h8;
    // mode evaluation delay
    localparam int         MODE_DELAY_US   = 400;
    localparam int         CLK_MHZ         = 200;
    localparam int         MODE_DELAY_CYC  = MODE_DELAY_US * CLK_MHZ;
    localparam int         MODE_CNT_W      = 17;

    typedef enum logic [3:0] {
        I_IDLE  = 4'h0,
        I_ADDR  = 4'h1,
        I_AACK  = 4'h3,
        I_IDX   = 4'h2,
        I_IACK  = 4'h6,
        I_WDATA = 4'h7,
        I_WACK  = 4'h5,
        I_RDATA = 4'h4,
        I_RACK  = 4'hC
    } lpc_i2c_st_t;

    typedef enum logic [1:0] {
        S_OFF   = 2'h0,
        S_ONEX  = 2'h1,
        S_WAIT  = 2'h3,
        S_BOOST = 2'h2
    } lpc_seq_st_t;
endpackage

// ### verilog/lpc_reg_if.sv
`timescale 1ns/1ps
interface lpc_reg_if;
    import lpc_pkg::*;
    logic              wrEn;
    logic              clr;
    logic [1:0]        addr;
    logic [7:0]        wdata;
    logic [7:0]        rdata;
    logic [CODE_W-1:0] codeA;
    logic [CODE_W-1:0] codeB;
    logic [CODE_W-1:0] codeC;
    logic [CODE_W-1:0] onMask;
    modport bank (input wrEn, clr, addr, wdata, output rdata, codeA, codeB, codeC, onMask);
    modport ctrl (output wrEn, clr, addr, wdata, input rdata, codeA, codeB, codeC, onMask);
endinterface

// ### verilog/lpc_sync.sv
`timescale 1ns/1ps
module lpc_sync
    import lpc_pkg::*;
#(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         mclk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);
    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage2_reg;
    logic [W-1:0] stage3_reg;
    logic [W-1:0] filt_reg;

    // three-stage chain; first stage feeds only the second
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            stage1_reg <= RST_VAL;
            stage2_reg <= RST_VAL;
            stage3_reg <= RST_VAL;
        end else begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // a bit changes once stages two and three agree
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            filt_reg <= RST_VAL;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (stage2_reg[i] == stage3_reg[i]) begin
                    filt_reg[i] <= stage2_reg[i];
                end
            end
        end
    end

    assign syncOut = filt_reg;
endmodule

// ### verilog/lpc_reg_bank.sv
`timescale 1ns/1ps
module lpc_reg_bank
    import lpc_pkg::*;
(
    input  wire logic mclk,
    input  wire logic resetn,
    lpc_reg_if.bank   rif
);
    logic [CODE_W-1:0] mem_reg [4];
    logic [7:0]        rdata_reg;

    // storage, cleared in shutdown; top bits never stored
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 4; i++) begin
                mem_reg[i] <= CODE_RESET;
            end
        end else if (rif.clr) begin
            for (int i = 0; i < 4; i++) begin
                mem_reg[i] <= CODE_RESET;
            end
        end else if (rif.wrEn) begin
            mem_reg[rif.addr] <= rif.wdata[CODE_W-1:0];
        end
    end

    // registered read port, upper bits zero
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= {2'b00, mem_reg[rif.addr]};
        end
    end

    assign rif.rdata  = rdata_reg;
    assign rif.codeA  = mem_reg[0];
    assign rif.codeB  = mem_reg[1];
    assign rif.codeC  = mem_reg[2];
    assign rif.onMask = mem_reg[3];

    a_bank_write: assert property (
        @(posedge mclk) disable iff (!resetn)
        (rif.wrEn && !rif.clr) |=> mem_reg[$past(rif.addr)] == $past(rif.wdata[5:0]))
        else $error("register write not stored");
    a_bank_read: assert property (
        @(posedge mclk) disable iff (!resetn)
        $stable(rif.addr) && !rif.wrEn && !rif.clr
        |=> rdata_reg == {2'b00, mem_reg[$past(rif.addr)]})
        else $error("read data does not match register");
    a_top_zero: assert property (
        @(posedge mclk) disable iff (!resetn)
        rif.clr |=> ##1 (rdata_reg == 8'h00 && mem_reg[3] == 6'h00))
        else $error("registers not cleared in shutdown");
endmodule

// ### verilog/lpc_top.sv
`timescale 1ns/1ps
module lpc_top
    import lpc_pkg::*;
#(
    parameter int unsigned MODE_DELAY_CYCLES = MODE_DELAY_CYC
) (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        sclIn,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOeN,
    input  wire logic        enableIn,
    input  wire logic        supplyUndervoltageLockout,
    input  wire logic        regulationOk,
    output logic [5:0]       ledChannelOutputs,
    output logic [CODE_W-1:0] pairACode,
    output logic [CODE_W-1:0] pairBCode,
    output logic [CODE_W-1:0] pairCCode,
    output logic             pumpBoost,
    output logic             shutdownActive
);
    localparam logic [MODE_CNT_W-1:0] DELAY_LAST = MODE_CNT_W'(MODE_DELAY_CYCLES - 1);

    lpc_reg_if rif ();

    logic [4:0]        pinSync;
    logic              sclF;
    logic              sdaF;
    logic              enF;
    logic              uvloF;
    logic              regOkF;
    logic              sclPrev_reg;
    logic              sdaPrev_reg;
    logic              sclRise;
    logic              sclFall;
    logic              startCond;
    logic              stopCond;
    lpc_i2c_st_t       i2cSt_reg;
    logic [7:0]        shift_reg;
    logic [3:0]        bitCnt_reg;
    logic              rw_reg;
    logic [7:0]        idx_reg;
    logic              sdaOeN_reg;
    logic              wr_reg;
    logic              onOffWrite;
    lpc_seq_st_t       seqSt_reg;
    logic [MODE_CNT_W-1:0] waitCnt_reg;
    logic [5:0]        ledChannelOutputs_reg;
    logic [CODE_W-1:0] pairACode_reg;
    logic [CODE_W-1:0] pairBCode_reg;
    logic [CODE_W-1:0] pairCCode_reg;
    logic              pumpBoost_reg;
    logic              shutdownActive_reg;
    logic [7:0]        readByte;

    // index lies inside the register map
    function automatic logic idxValid(input logic [7:0] idx);
        return idx < NUM_REGS;
    endfunction

    // pin synchronisers: scl, sda idle high
    lpc_sync #(
        .W       (5),
        .RST_VAL (5'h03)
    ) u_sync (
        .mclk    (mclk),
        .resetn  (resetn),
        .asyncIn ({regulationOk, supplyUndervoltageLockout, enableIn, sdaIn, sclIn}),
        .syncOut (pinSync)
    );

    assign sclF   = pinSync[0];
    assign sdaF   = pinSync[1];
    assign enF    = pinSync[2];
    assign uvloF  = pinSync[3];
    assign regOkF = pinSync[4];

    lpc_reg_bank u_bank (
        .mclk   (mclk),
        .resetn (resetn),
        .rif    (rif.bank)
    );

    // bank hookup; registers clear while enable is low
    assign rif.clr   = ~enF;
    assign rif.wrEn  = wr_reg;
    assign rif.addr  = idx_reg[1:0];
    assign rif.wdata = shift_reg;
    assign readByte  = idxValid(idx_reg) ? rif.rdata : 8'h00;

    // bus edge history
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sclPrev_reg <= 1'b1;
            sdaPrev_reg <= 1'b1;
        end else begin
            sclPrev_reg <= sclF;
            sdaPrev_reg <= sdaF;
        end
    end

    // bus conditions
    assign sclRise   = sclF & ~sclPrev_reg;
    assign sclFall   = ~sclF & sclPrev_reg;
    assign startCond = sclF & sclPrev_reg & sdaPrev_reg & ~sdaF;
    assign stopCond  = sclF & sclPrev_reg & ~sdaPrev_reg & sdaF;

    // serial slave state machine
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            i2cSt_reg  <= I_IDLE;
            shift_reg  <= 8'h00;
            bitCnt_reg <= 4'h0;
            rw_reg     <= 1'b0;
            idx_reg    <= 8'h00;
            sdaOeN_reg <= 1'b1;
            wr_reg     <= 1'b0;
        end else begin
            wr_reg <= 1'b0;
            if (!enF) begin
                i2cSt_reg  <= I_IDLE;
                sdaOeN_reg <= 1'b1;
                bitCnt_reg <= 4'h0;
            end else if (startCond) begin
                // start or repeated start
                i2cSt_reg  <= I_ADDR;
                bitCnt_reg <= 4'h0;
                sdaOeN_reg <= 1'b1;
            end else if (stopCond) begin
                i2cSt_reg  <= I_IDLE;
                sdaOeN_reg <= 1'b1;
            end else begin
                case (i2cSt_reg)
                    I_ADDR, I_IDX, I_WDATA: begin
                        if (sclRise && bitCnt_reg < BYTE_BITS) begin
                            shift_reg  <= {shift_reg[6:0], sdaF};
                            bitCnt_reg <= bitCnt_reg + 4'h1;
                        end else if (sclFall && bitCnt_reg == BYTE_BITS) begin
                            bitCnt_reg <= 4'h0;
                            if (i2cSt_reg == I_ADDR) begin
                                if (shift_reg[7:1] == SLAVE_ADDR) begin
                                    sdaOeN_reg <= 1'b0;
                                    rw_reg     <= shift_reg[0];
                                    i2cSt_reg  <= I_AACK;
                                end else begin
                                    i2cSt_reg <= I_IDLE;
                                end
                            end else if (i2cSt_reg == I_IDX) begin
                                idx_reg    <= shift_reg;
                                sdaOeN_reg <= 1'b0;
                                i2cSt_reg  <= I_IACK;
                            end else begin
                                wr_reg     <= idxValid(idx_reg);
                                sdaOeN_reg <= 1'b0;
                                i2cSt_reg  <= I_WACK;
                            end
                        end
                    end
                    I_AACK: begin
                        if (sclFall) begin
                            if (rw_reg) begin
                                // first read bit goes out as ack ends
                                sdaOeN_reg <= readByte[7];
                                shift_reg  <= {readByte[6:0], 1'b0};
                                bitCnt_reg <= 4'h1;
                                i2cSt_reg  <= I_RDATA;
                            end else begin
                                sdaOeN_reg <= 1'b1;
                                i2cSt_reg  <= I_IDX;
                            end
                        end
                    end
                    I_IACK: begin
                        if (sclFall) begin
                            sdaOeN_reg <= 1'b1;
                            i2cSt_reg  <= I_WDATA;
                        end
                    end
                    I_WACK: begin
                        if (sclFall) begin
                            sdaOeN_reg <= 1'b1;
                            idx_reg    <= idx_reg + 8'h01;
                            i2cSt_reg  <= I_WDATA;
                        end
                    end
                    I_RDATA: begin
                        if (sclFall) begin
                            if (bitCnt_reg == BYTE_BITS) begin
                                sdaOeN_reg <= 1'b1;
                                bitCnt_reg <= 4'h0;
                                i2cSt_reg  <= I_RACK;
                            end else begin
                                sdaOeN_reg <= shift_reg[7];
                                shift_reg  <= {shift_reg[6:0], 1'b0};
                                bitCnt_reg <= bitCnt_reg + 4'h1;
                            end
                        end
                    end
                    I_RACK: begin
                        if (sclRise) begin
                            if (sdaF) begin
                                i2cSt_reg <= I_IDLE;
                            end else begin
                                idx_reg <= idx_reg + 8'h01;
                            end
                        end else if (sclFall) begin
                            sdaOeN_reg <= readByte[7];
                            shift_reg  <= {readByte[6:0], 1'b0};
                            bitCnt_reg <= 4'h1;
                            i2cSt_reg  <= I_RDATA;
                        end
                    end
                    I_IDLE: begin
                        sdaOeN_reg <= 1'b1;
                    end
                    default: begin
                        i2cSt_reg  <= I_IDLE;
                        sdaOeN_reg <= 1'b1;
                    end
                endcase
            end
        end
    end

    // write into the on/off mask
    assign onOffWrite = wr_reg && (idx_reg == IDX_ON_OFF);

    // 1x / 1.5x mode sequencer
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            seqSt_reg   <= S_OFF;
            waitCnt_reg <= '0;
        end else if (!enF) begin
            seqSt_reg   <= S_OFF;
            waitCnt_reg <= '0;
        end else if (onOffWrite) begin
            seqSt_reg   <= S_ONEX;
            waitCnt_reg <= '0;
        end else begin
            case (seqSt_reg)
                S_OFF: begin
                    seqSt_reg <= S_ONEX;
                end
                S_ONEX: begin
                    if (!regOkF) begin
                        seqSt_reg   <= S_WAIT;
                        waitCnt_reg <= '0;
                    end
                end
                S_WAIT: begin
                    if (regOkF) begin
                        seqSt_reg <= S_ONEX;
                    end else if (waitCnt_reg == DELAY_LAST) begin
                        seqSt_reg <= S_BOOST;
                    end else begin
                        waitCnt_reg <= waitCnt_reg + 1'b1;
                    end
                end
                S_BOOST: begin
                    seqSt_reg <= S_BOOST;
                end
                default: begin
                    seqSt_reg <= S_OFF;
                end
            endcase
        end
    end

    // output flops: channel gating, pair codes, pump mode
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ledChannelOutputs_reg <= 6'h00;
            pairACode_reg         <= CODE_RESET;
            pairBCode_reg         <= CODE_RESET;
            pairCCode_reg         <= CODE_RESET;
            pumpBoost_reg         <= 1'b0;
            shutdownActive_reg    <= 1'b1;
        end else begin
            shutdownActive_reg    <= ~enF;
            ledChannelOutputs_reg <= (enF && !uvloF) ? rif.onMask : 6'h00;
            pairACode_reg         <= rif.codeA;
            pairBCode_reg         <= rif.codeB;
            pairCCode_reg         <= rif.codeC;
            pumpBoost_reg         <= enF && (seqSt_reg == S_BOOST);
        end
    end

    assign sdaOut            = 1'b0;
    assign sdaOeN            = sdaOeN_reg;
    assign ledChannelOutputs = ledChannelOutputs_reg;
    assign pairACode         = pairACode_reg;
    assign pairBCode         = pairBCode_reg;
    assign pairCCode         = pairCCode_reg;
    assign pumpBoost         = pumpBoost_reg;
    assign shutdownActive    = shutdownActive_reg;

    a_supply_undervoltage_lockout_off: assert property (
        @(posedge mclk) disable iff (!resetn)
        uvloF |=> ledChannelOutputs_reg == 6'h00)
        else $error("channel on during undervoltage");
    a_enable_zero: assert property (
        @(posedge mclk) disable iff (!resetn)
        $rose(enF) |=> ledChannelOutputs_reg == 6'h00)
        else $error("channel on right after enable");
    a_shutdown_hold: assert property (
        @(posedge mclk) disable iff (!resetn)
        !enF |=> shutdownActive_reg && seqSt_reg == S_OFF)
        else $error("not in shutdown while enable low");
    a_shutdown_hiz: assert property (
        @(posedge mclk) disable iff (!resetn)
        shutdownActive_reg |-> ledChannelOutputs_reg == 6'h00 && !pumpBoost_reg)
        else $error("channel sinking in shutdown");
    a_pair_drive: assert property (
        @(posedge mclk) disable iff (!resetn)
        1'b1 |=> pairACode_reg == $past(rif.codeA) && pairBCode_reg == $past(rif.codeB)
                 && pairCCode_reg == $past(rif.codeC))
        else $error("pair code not following register");
    a_mask_map: assert property (
        @(posedge mclk) disable iff (!resetn)
        enF && !uvloF |=> ledChannelOutputs_reg == $past(rif.onMask))
        else $error("channel state not following mask");
    a_stay_onex: assert property (
        @(posedge mclk) disable iff (!resetn)
        seqSt_reg == S_ONEX && regOkF && enF |=> seqSt_reg == S_ONEX)
        else $error("left 1x while regulating");
    a_boost_delay: assert property (
        @(posedge mclk) disable iff (!resetn)
        $rose(seqSt_reg == S_BOOST) |-> $past(waitCnt_reg) == DELAY_LAST
                                       && $past(seqSt_reg) == S_WAIT)
        else $error("1.5x entered without full delay");
    a_exit_onex: assert property (
        @(posedge mclk) disable iff (!resetn)
        $rose(enF) |=> seqSt_reg == S_ONEX)
        else $error("shutdown exit did not start in 1x");
    a_mask_restart: assert property (
        @(posedge mclk) disable iff (!resetn)
        onOffWrite && enF |=> seqSt_reg == S_ONEX && waitCnt_reg == '0)
        else $error("mask write did not restart evaluation");
    a_addr_ignore: assert property (
        @(posedge mclk) disable iff (!resetn)
        i2cSt_reg == I_ADDR && sclFall && bitCnt_reg == BYTE_BITS
        && shift_reg[7:1] != SLAVE_ADDR |=> sdaOeN_reg && i2cSt_reg == I_IDLE)
        else $error("acknowledged a foreign address");
    a_read_nack: assert property (
        @(posedge mclk) disable iff (!resetn)
        enF && i2cSt_reg == I_RACK && sclRise && sdaF |=> i2cSt_reg == I_IDLE && sdaOeN_reg)
        else $error("read continued after not-acknowledge");
endmodule

// ### tb/lpc_bus_master.sv
`timescale 1ns/1ps
module lpc_bus_master
    import lpc_pkg::*;
#(
    parameter int HALF = 12
) (
    input  wire logic mclk,
    input  wire logic sdaLine,
    output logic      scl,
    output logic      sdaDrv
);
    // bus idles high, data released to the pull-up
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    task automatic hw();
        repeat (HALF) @(negedge mclk);
    endtask
    // start and repeated start: data falls while clock is high
    task automatic start();
        sdaDrv = 1'b1;
        hw();
        scl = 1'b1;
        hw();
        sdaDrv = 1'b0;
        hw();
        scl = 1'b0;
        hw();
    endtask
    task automatic stop();
        sdaDrv = 1'b0;
        hw();
        scl = 1'b1;
        hw();
        sdaDrv = 1'b1;
        hw();
    endtask
    // one bit, data set while clock is low, line sampled at end of high
    task automatic bitx(input logic b, output logic s);
        sdaDrv = b;
        hw();
        scl = 1'b1;
        hw();
        s = sdaLine;
        scl = 1'b0;
        hw();
    endtask
    task automatic wrByte(input logic [7:0] d, output logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(d[i], s);
        bitx(1'b1, nack);
    endtask
    task automatic wrReg(input logic [6:0] a, input logic [7:0] idx, d, output logic nack);
        logic n2;
        start();
        wrByte({a, 1'b0}, nack);
        wrByte(idx, n2);
        wrByte(d, n2);
        stop();
    endtask
    // index write, repeated start, one byte read, then nack and stop
    task automatic rdReg(input logic [7:0] idx, output logic [7:0] d);
        logic n2;
        start();
        wrByte({SLAVE_ADDR, 1'b0}, n2);
        wrByte(idx, n2);
        start();
        wrByte({SLAVE_ADDR, 1'b1}, n2);
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(1'b1, n2);
        stop();
    endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import lpc_pkg::*;
;
    localparam int DLY = 20;
    logic              mclk, resetn, scl, sdaDrv, sdaOut, sdaOeN, enableIn, supply_undervoltage_lockout, regOk;
    logic              boost, shdn, nack;
    // open-drain data line with pull-up: low when the slave drives
    wire               sdaLine = sdaDrv & (sdaOeN | sdaOut);
    logic [5:0]        leds;
    logic [CODE_W-1:0] codeA, codeB, codeC;
    logic [7:0]        rdVal, d;
    logic [11:0]       notes[$];
    int                fail_count, cmp_count, cyc, rnd;
    event              chk;
    string             nm[8] = '{"leds", "codeA", "codeB", "codeC", "boost", "shutdown",
                                 "readback", "nack"};
    always #2.5 mclk = ~mclk;
    lpc_bus_master m (.mclk(mclk), .sdaLine(sdaLine), .scl(scl), .sdaDrv(sdaDrv));
    lpc_top #(.MODE_DELAY_CYCLES(DLY)) i_dut (
        .mclk(mclk), .resetn(resetn), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
        .sdaOeN(sdaOeN), .enableIn(enableIn), .supplyUndervoltageLockout(supply_undervoltage_lockout),
        .regulationOk(regOk), .ledChannelOutputs(leds), .pairACode(codeA), .pairBCode(codeB),
        .pairCCode(codeC), .pumpBoost(boost), .shutdownActive(shdn));
    function automatic logic [7:0] look(input logic [3:0] sel);
        case (sel)
            0: return {2'h0, leds};
            1: return {2'h0, codeA};
            2: return {2'h0, codeB};
            3: return {2'h0, codeC};
            4: return {7'h00, boost};
            5: return {7'h00, shdn};
            6: return rdVal;
            default: return {7'h00, nack};
        endcase
    endfunction
    // driver notes the expectation, monitor compares against the outputs
    task automatic check(input int sel, input logic [7:0] exp);
        notes.push_back({sel[3:0], exp});
        ->chk;
        #1;
    endtask
    always begin
        @(chk);
        cmp_count++;
        if (look(notes[0][11:8]) !== notes[0][7:0]) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm[notes[0][11:8]], notes[0][7:0],
                     look(notes[0][11:8]));
        end
        void'(notes.pop_front());
    end
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        mclk = 1'b0;
        resetn = 1'b0;
        enableIn = 1'b0;
        supply_undervoltage_lockout = 1'b0;
        regOk = 1'b1;
        rnd = $urandom(43327);
        repeat (20) @(negedge mclk);
        check(5, 8'h01);
        check(0, 8'h00);
        resetn = 1'b1;
        repeat (4) @(negedge mclk);
        enableIn = 1'b1;
        repeat (12) @(negedge mclk);
        check(5, 8'h00);
        check(1, 8'h00);
        check(4, 8'h00);
        $display("test wake done");
        // each pair code with random top bits, then read back
        for (int i = 0; i < 3; i++) begin
            d = 8'($urandom);
            m.wrReg(SLAVE_ADDR, 8'(i), d, nack);
            check(7, 8'h00);
            check(i + 1, {2'h0, d[5:0]});
            m.rdReg(8'(i), rdVal);
            check(6, {2'h0, d[5:0]});
        end
        $display("test codes done");
        for (int i = 0; i < 6; i++) begin
            m.wrReg(SLAVE_ADDR, IDX_ON_OFF, 8'hC0 | (8'h01 << i), nack);
            check(0, 8'h01 << i);
        end
        m.rdReg(IDX_ON_OFF, rdVal);
        check(6, 8'h20);
        m.wrReg(SLAVE_ADDR ^ 7'h01, IDX_ON_OFF, 8'h3F, nack);
        check(7, 8'h01);
        check(0, 8'h20);
        // index outside the map: write dropped, reads back zero
        m.wrReg(SLAVE_ADDR, 8'h04, 8'h15, nack);
        m.rdReg(8'h04, rdVal);
        check(6, 8'h00);
        check(0, 8'h20);
        $display("test mask done");
        m.wrReg(SLAVE_ADDR, IDX_ON_OFF, 8'h3F, nack);
        supply_undervoltage_lockout = 1'b1;
        repeat (10) @(negedge mclk);
        check(0, 8'h00);
        supply_undervoltage_lockout = 1'b0;
        repeat (10) @(negedge mclk);
        check(0, 8'h3F);
        regOk = 1'b0;
        repeat (DLY / 2) @(negedge mclk);
        check(4, 8'h00);
        repeat (DLY + 10) @(negedge mclk);
        check(4, 8'h01);
        regOk = 1'b1;
        m.wrReg(SLAVE_ADDR, IDX_ON_OFF, 8'h3F, nack);
        check(4, 8'h00);
        $display("test mode done");
        regOk = 1'b0;
        repeat (DLY + 14) @(negedge mclk);
        check(4, 8'h01);
        enableIn = 1'b0;
        repeat (10) @(negedge mclk);
        check(5, 8'h01);
        check(0, 8'h00);
        check(4, 8'h00);
        regOk = 1'b1;
        enableIn = 1'b1;
        repeat (10) @(negedge mclk);
        check(5, 8'h00);
        check(2, 8'h00);
        check(0, 8'h00);
        $display("test shutdown done");
        conclude();
    end
endmodule
